// [rtl/bsr_pkg.sv]
/*
  Constants, carrier types and the lane-mask helper for the two-word-burst
  double-data-rate SRAM model. Assumes both input clocks arrive as ordinary
  inputs that are synchronous to the core clock.
*/
package bsr_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int BSR_DATA_W    = 18;
  localparam int BSR_ADDR_W    = 19;
  localparam int BSR_LANE_W    = 9;
  localparam int BSR_MAX_LANES = 4;
  localparam int BSR_MAX_W     = BSR_LANE_W * BSR_MAX_LANES;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic BSR_OE_N_RST = 1'b1;
  localparam logic BSR_CLK_RST  = 1'b1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic load_n;
    logic dir_select;
  } bsr_ctl_t;

  typedef enum logic [2:0] {
    BSR_OUT_IDLE = 3'b001,
    BSR_OUT_LOW  = 3'b010,
    BSR_OUT_HIGH = 3'b100
  } bsr_out_state_t;

  // Expands active-low byte enables into an active-high bit mask
  function automatic logic [BSR_MAX_W-1:0] bsr_lane_mask(input logic [BSR_MAX_LANES-1:0] be_n);
    logic [BSR_MAX_W-1:0] m;
    m = '0;
    for (int i = 0; i < BSR_MAX_LANES; i++) begin
      m[i*BSR_LANE_W +: BSR_LANE_W] = {BSR_LANE_W{~be_n[i]}};
    end
    return m;
  endfunction

endpackage

// [rtl/bsr_array.sv]
/*
  Storage array: one entry per burst address, two beats wide, bit-masked
  write and combinational read. Assumes the caller registers write requests.
*/
`timescale 1ns/1ps
module bsr_array
  import bsr_pkg::*;
#(
  parameter int DATA_W = BSR_DATA_W,
  parameter int ADDR_W = BSR_ADDR_W
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_we,
  input  wire logic [ADDR_W-1:0]   i_waddr,
  input  wire logic [2*DATA_W-1:0] i_wdata,
  input  wire logic [2*DATA_W-1:0] i_wmask,
  input  wire logic [ADDR_W-1:0]   i_raddr,
  output logic      [2*DATA_W-1:0] o_rdata
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // No reset: contents are undefined at power-up, as in the real part
  logic [2*DATA_W-1:0] mem_q [2**ADDR_W];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= (i_wdata & i_wmask) | (mem_q[i_waddr] & ~i_wmask);
    end
  end

  assign o_rdata = mem_q[i_raddr];

endmodule

// [rtl/bsr_sram.sv]
/*
  Command, burst and byte-write logic of a two-word-burst DDR SRAM with
  2.5-cycle read latency. Assumes i_k and i_k_n are synchronous inputs
  sampled by the core clock, slow enough that each level lasts at least
  one core cycle, and that the controller respects read-to-write spacing.
*/
`timescale 1ns/1ps
module bsr_sram
  import bsr_pkg::*;
#(
  parameter int DATA_W = BSR_DATA_W,
  parameter int ADDR_W = BSR_ADDR_W
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_k,
  input  wire logic                  i_k_n,
  input  wire bsr_ctl_t              i_ctl,
  input  wire logic [ADDR_W-1:0]     i_addr,
  input  wire logic [DATA_W/9-1:0]   i_byte_lane_enable_n,
  input  wire logic [DATA_W-1:0]     i_dq,
  output logic      [DATA_W-1:0]     o_dq,
  output logic                       o_dq_oe_n
);

  localparam int LANES = DATA_W / BSR_LANE_W;

  // Only the two documented widths have a lane layout
  if (!(DATA_W == 18 || DATA_W == 36) || ADDR_W < 1 || ADDR_W > 24) begin
    $error("bsr_sram: DATA_W must be 18 or 36, ADDR_W 1..24");
  end

  // ----------------------------------------------------------------------
  // Clock edge detection
  // ----------------------------------------------------------------------
  logic k_q;
  logic kn_q;
  logic pos_edge;
  logic neg_edge;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      k_q  <= BSR_CLK_RST;
      kn_q <= BSR_CLK_RST;
    end else begin
      k_q  <= i_k;
      kn_q <= i_k_n;
    end
  end

  // A stopped clock gives no edges, so every stage but the wr_we_q strobe simply holds
  assign pos_edge = i_k & ~k_q;
  assign neg_edge = i_k_n & ~kn_q;

  logic [BSR_MAX_LANES-1:0] be_n_ext;
  logic [BSR_MAX_W-1:0]     full_mask;
  logic [DATA_W-1:0]        lane_mask;

  // Unused upper lanes are padded inactive so they can never write
  always_comb begin
    be_n_ext            = '1;
    be_n_ext[LANES-1:0] = i_byte_lane_enable_n;
    full_mask           = bsr_lane_mask(be_n_ext);
    lane_mask           = full_mask[DATA_W-1:0];
  end

  // ----------------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------------
  logic              wa_vld_q;
  logic [ADDR_W-1:0] wa_addr_q;
  logic              wd_wait_q;
  logic [ADDR_W-1:0] wd_addr_q;
  logic [DATA_W-1:0] wd_data0_q;
  logic [DATA_W-1:0] wd_mask0_q;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wa_vld_q  <= 1'b0;
      wa_addr_q <= '0;
    end else if (pos_edge) begin
      wa_vld_q  <= ~i_ctl.load_n & ~i_ctl.dir_select;
      wa_addr_q <= i_addr;
    end
  end

  // First beat at the K rise after the command, with its own enables
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wd_wait_q  <= 1'b0;
      wd_addr_q  <= '0;
      wd_data0_q <= '0;
      wd_mask0_q <= '0;
    end else if (pos_edge) begin
      wd_wait_q  <= wa_vld_q;
      if (wa_vld_q) begin
        wd_addr_q  <= wa_addr_q;
        wd_data0_q <= i_dq;
        wd_mask0_q <= lane_mask;
      end
    end else if (neg_edge) begin
      wd_wait_q  <= 1'b0;
    end
  end

  // Posted write: the last burst stays here as a bypass source
  logic                wr_we_q;
  logic [ADDR_W-1:0]   post_addr_q;
  logic [2*DATA_W-1:0] post_data_q;
  logic [2*DATA_W-1:0] post_mask_q;
  logic                post_vld_q;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_we_q     <= 1'b0;
      post_vld_q  <= 1'b0;
      post_addr_q <= '0;
      post_data_q <= '0;
      post_mask_q <= '0;
    end else begin
      wr_we_q <= neg_edge & wd_wait_q;
      if (neg_edge && wd_wait_q) begin
        post_vld_q  <= 1'b1;
        post_addr_q <= wd_addr_q;
        post_data_q <= {i_dq, wd_data0_q};
        post_mask_q <= {lane_mask, wd_mask0_q};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0]   rd1_addr_q;
  logic [2*DATA_W-1:0] arr_rdata;
  logic [2*DATA_W-1:0] rd_merged;

  bsr_array #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_array (
    .i_core_clk (i_core_clk),
    .i_we       (wr_we_q),
    .i_waddr    (post_addr_q),
    .i_wdata    (post_data_q),
    .i_wmask    (post_mask_q),
    .i_raddr    (rd1_addr_q),
    .o_rdata    (arr_rdata)
  );

  // Newest write data wins over the array for every enabled byte
  always_comb begin
    rd_merged = arr_rdata;
    if (post_vld_q && post_addr_q == rd1_addr_q) begin
      rd_merged = (post_data_q & post_mask_q) | (arr_rdata & ~post_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Read pipeline
  // ----------------------------------------------------------------------
  logic              rd0_vld_q;
  logic [ADDR_W-1:0] rd0_addr_q;
  logic              rd1_vld_q;
  logic              rf_vld_q;
  logic [2*DATA_W-1:0] rf_data_q;

  // Command at K rise t, then two further K rises before fetch
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd0_vld_q  <= 1'b0;
      rd0_addr_q <= '0;
      rd1_vld_q  <= 1'b0;
      rd1_addr_q <= '0;
      rf_vld_q   <= 1'b0;
      rf_data_q  <= '0;
    end else if (pos_edge) begin
      rd0_vld_q  <= ~i_ctl.load_n & i_ctl.dir_select;
      rd0_addr_q <= i_addr;
      rd1_vld_q  <= rd0_vld_q;
      rd1_addr_q <= rd0_addr_q;
      rf_vld_q   <= rd1_vld_q;
      rf_data_q  <= rd_merged;
    end else if (neg_edge) begin
      rf_vld_q   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------
  bsr_out_state_t      out_state_q;
  logic [DATA_W-1:0]   hi_beat_q;

  // Pins start released; a K# rise with no new beat releases them again,
  // so a neighbouring bank can drive at the very next beat
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_state_q <= BSR_OUT_IDLE;
      o_dq        <= '0;
      o_dq_oe_n   <= BSR_OE_N_RST;
      hi_beat_q   <= '0;
    end else if (neg_edge) begin
      case (out_state_q)
        BSR_OUT_IDLE, BSR_OUT_HIGH: begin
          if (rf_vld_q) begin
            o_dq        <= rf_data_q[DATA_W-1:0];
            hi_beat_q   <= rf_data_q[2*DATA_W-1:DATA_W];
            o_dq_oe_n   <= 1'b0;
            out_state_q <= BSR_OUT_LOW;
          end else begin
            o_dq_oe_n   <= 1'b1;
            out_state_q <= BSR_OUT_IDLE;
          end
        end
        default: begin
          out_state_q <= out_state_q;
        end
      endcase
    end else if (pos_edge) begin
      case (out_state_q)
        BSR_OUT_LOW: begin
          o_dq        <= hi_beat_q;
          out_state_q <= BSR_OUT_HIGH;
        end
        default: begin
          out_state_q <= out_state_q;
        end
      endcase
    end
  end

endmodule

// [verification/bsr_sram_assertions.sv]
/*
  Timing checker for the burst SRAM.
  Assumes it sees only the ports of bsr_sram.
*/
`timescale 1ns/1ps
module bsr_sram_assertions
  import bsr_pkg::*;
#(
  parameter int DATA_W = BSR_DATA_W,
  parameter int ADDR_W = BSR_ADDR_W
) (
  input wire logic              i_core_clk,
  input wire logic              i_rstn,
  input wire logic              i_k,
  input wire logic              i_k_n,
  input wire bsr_ctl_t          i_ctl,
  input wire logic [DATA_W-1:0] o_dq,
  input wire logic              o_dq_oe_n
);
  // ----------------
  // Edge tracking
  // ----------------
  logic       k_q;
  logic       kn_q;
  logic [2:0] age_q;
  wire        kr  = i_k & ~k_q;
  wire        knr = i_k_n & ~kn_q;
  // History resets high so a level seen at release is no edge
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      k_q  <= 1'b1;
      kn_q <= 1'b1;
    end else begin
      k_q  <= i_k;
      kn_q <= i_k_n;
    end
  end
  // K rises since the last read, saturating
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      age_q <= 3'h7;
    end else if (kr && !i_ctl.load_n && i_ctl.dir_select) begin
      age_q <= 3'h0;
    end else if (kr && age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  sequence rd_lo_s; knr && age_q == 3'h2; endsequence
  sequence rd_hi_s; kr && age_q == 3'h2; endsequence
  sequence nop_s; kr && i_ctl.load_n && age_q >= 3'h4; endsequence
  sequence wr_s; kr && !i_ctl.load_n && !i_ctl.dir_select && age_q >= 3'h4; endsequence
  reset_oe_a: assert property ($rose(i_rstn) |-> o_dq_oe_n)
    else $error("pins driven at reset release");
  oe_edge_a: assert property (!knr |=> $stable(o_dq_oe_n))
    else $error("enable moved off a K# rise");
  dq_edge_a: assert property (!(kr || knr) |=> $stable(o_dq))
    else $error("data moved off a clock rise");
  read_lo_a: assert property (rd_lo_s |=> !o_dq_oe_n [*4])
    else $error("first read beat not driven");
  read_hi_a: assert property (rd_hi_s |=> !o_dq_oe_n [*2])
    else $error("second read beat not driven");
  read_done_a: assert property (knr && age_q >= 3'h3 |=> o_dq_oe_n)
    else $error("pins not released after burst");
  nop_quiet_a: assert property (nop_s |=> o_dq_oe_n [*8])
    else $error("no-op drove the pins");
  write_quiet_a: assert property (wr_s |=> o_dq_oe_n [*8])
    else $error("write drove the pins");
endmodule
bind bsr_sram bsr_sram_assertions #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk_u (
  .i_core_clk(i_core_clk),
  .i_rstn    (i_rstn),
  .i_k       (i_k),
  .i_k_n     (i_k_n),
  .i_ctl     (i_ctl),
  .o_dq      (o_dq),
  .o_dq_oe_n (o_dq_oe_n)
);

// [verification/bsr_ctrl_model.sv]
/*
  Memory controller model: makes K and K#, issues commands and beats.
  Assumes the core clock is four times the K rate.
*/
`timescale 1ns/1ps
module bsr_ctrl_model
  import bsr_pkg::*;
(
  input  wire logic              i_core_clk,
  output logic                   o_k,
  output logic                   o_k_n,
  output bsr_ctl_t               o_ctl,
  output logic [BSR_ADDR_W-1:0]  o_addr,
  output logic [1:0]             o_be_n,
  output logic [BSR_DATA_W-1:0]  o_dq
);
  logic [1:0] ph_q   = 2'h0;
  logic       stop_q = 1'b0;
  // K and K# rise two core cycles apart, never together; stop_q freezes both
  always_ff @(posedge i_core_clk) begin
    if (!stop_q) begin
      ph_q <= ph_q + 2'h1;
    end
  end
  assign o_k   = ~ph_q[1];
  assign o_k_n = ph_q[1];
  initial begin
    o_ctl  = 2'h3;
    o_addr = '0;
    o_be_n = 2'h3;
    o_dq   = '0;
  end
  // One K cycle: command and beat 0 at K, beat 1 at K#
  task automatic kcyc(input logic ld_n, dir, input logic [18:0] a,
                      input logic [17:0] d0, d1, input logic [1:0] b0, b1);
    @(posedge i_core_clk iff ph_q == 2'h3);
    o_ctl  <= {ld_n, dir};
    o_addr <= a;
    o_dq   <= d0;
    o_be_n <= b0;
    @(posedge i_core_clk iff ph_q == 2'h1);
    o_ctl.load_n <= 1'b1;
    o_dq   <= d1;
    o_be_n <= b1;
  endtask
  // Holds both clocks where they stand for n core cycles
  task automatic pause(input int n);
    stop_q <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    stop_q <= 1'b0;
  endtask
endmodule

// [verification/tb.sv]
/*
  Self-checking bench for bsr_sram.
  Assumes bsr_ctrl_model drives all pins except the core clock and reset.
*/
`timescale 1ns/1ps
module tb;
  import bsr_pkg::*;
  logic                  clk;
  logic                  rstn;
  logic                  k;
  logic                  k_n;
  bsr_ctl_t              ctl;
  logic [BSR_ADDR_W-1:0] addr;
  logic [1:0]            be_n;
  logic [BSR_DATA_W-1:0] dq;
  logic [BSR_DATA_W-1:0] q;
  logic                  oe_n;
  logic [2*BSR_DATA_W-1:0] q36;
  logic                    oe36_n;
  int                    err_count;
  int                    checks_done;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  bsr_ctrl_model ctl_u (.i_core_clk(clk), .o_k(k), .o_k_n(k_n), .o_ctl(ctl),
                        .o_addr(addr), .o_be_n(be_n), .o_dq(dq));
  bsr_sram dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_k(k), .i_k_n(k_n), .i_ctl(ctl),
                  .i_addr(addr), .i_byte_lane_enable_n(be_n), .i_dq(dq),
                  .o_dq(q), .o_dq_oe_n(oe_n));
  // Wide configuration on the same pins: upper lanes mirror the lower ones, data inverted
  bsr_sram #(.DATA_W(2 * BSR_DATA_W), .ADDR_W(BSR_ADDR_W - 1)) dut_wide_u (
    .i_core_clk(clk), .i_rstn(rstn), .i_k(k), .i_k_n(k_n), .i_ctl(ctl), .i_addr(addr[17:0]),
    .i_byte_lane_enable_n({be_n, be_n}), .i_dq({~dq, dq}), .o_dq(q36), .o_dq_oe_n(oe36_n));
  task automatic chk(input logic [17:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [17:0] mrg(input logic [17:0] o, n, input logic [1:0] b);
    return (o & ~{{9{~b[1]}}, {9{~b[0]}}}) | (n & {{9{~b[1]}}, {9{~b[0]}}});
  endfunction
  // Reads n bursts back to back and checks every beat
  task automatic rd(input int n, input logic [18:0] a0, a1, input logic [3:0][17:0] e);
    for (int i = 0; i < n; i++) ctl_u.kcyc(1'b0, 1'b1, i ? a1 : a0, '1, '0, 2'h3, 2'h3);
    repeat (13 - 4 * n) @(posedge clk);
    for (int i = 0; i < 2 * n; i++) begin
      @(negedge clk);
      chk(q, e[i]);
      chk({17'h0, oe_n}, 18'h0);
      chk(q36[17:0], e[i]);
      chk(q36[35:18], ~e[i]);
      repeat (2) @(posedge clk);
    end
    @(negedge clk);
    chk({17'h0, oe_n}, 18'h1);
    chk({17'h0, oe36_n}, 18'h1);
  endtask
  task automatic t_idle();
    for (int i = 0; i < 3; i++) ctl_u.kcyc(1'b1, 1'b1, '1, '1, '0, 2'h0, 2'h0);
    @(negedge clk);
    chk({17'h0, oe_n}, 18'h1);
    $display("test idle done");
  endtask
  task automatic t_bypass();
    ctl_u.kcyc(1'b0, 1'b0, 19'h10, '0, '0, 2'h3, 2'h3);
    ctl_u.kcyc(1'b1, 1'b1, '0, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
    rd(1, 19'h10, '0, {36'h0, 18'h15A5A, 18'h2A5A5});
    $display("test bypass done");
  endtask
  // Reads follow the last write after one no-op K cycle, which carries its beats
  task automatic t_lanes();
    logic [17:0] e0;
    logic [17:0] e1;
    e0 = mrg(18'h12345, 18'h3FFFF, 2'h2);
    e1 = mrg(18'h2468A, 18'h0ABCD, 2'h1);
    ctl_u.kcyc(1'b0, 1'b0, 19'h20, '0, '0, 2'h3, 2'h3);
    ctl_u.kcyc(1'b0, 1'b0, 19'h20, 18'h12345, 18'h2468A, 2'h0, 2'h0);
    ctl_u.kcyc(1'b0, 1'b0, 19'h20, 18'h3FFFF, 18'h0ABCD, 2'h2, 2'h1);
    ctl_u.kcyc(1'b0, 1'b0, 19'h30, 18'h15555, 18'h2AAAA, 2'h3, 2'h3);
    ctl_u.kcyc(1'b1, 1'b0, '0, 18'h00F0F, 18'h3F0F0, 2'h0, 2'h0);
    rd(2, 19'h20, 19'h30, {18'h3F0F0, 18'h00F0F, e1, e0});
    $display("test lanes done");
  endtask
  // Clocks frozen mid-burst: the first beat must stand until they resume
  task automatic t_stop();
    ctl_u.kcyc(1'b0, 1'b1, 19'h10, '1, '0, 2'h3, 2'h3);
    repeat (9) @(posedge clk);
    ctl_u.pause(16);
    @(negedge clk);
    chk(q, 18'h2A5A5);
    chk({17'h0, oe_n}, 18'h0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(q, 18'h15A5A);
    $display("test stop done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    $display("MISMATCH at %0t: run hung", $time);
    give_verdict();
  end
  initial begin
    err_count   = 0;
    checks_done = 0;
    rstn        = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_idle();
    t_bypass();
    t_lanes();
    t_stop();
    give_verdict();
  end
endmodule
